/* File: logic/atm_rx_cell_filter_fifo.sv */
// Receive cell back end: HCS check, filter, counters, GFC port, cell FIFO.
// Assumes delineated bytes on core_clk and an ATM layer read clock pin.
// How it works
// - Cells reach the FIFO only in SYNC; filtering is enabled by a control.
// - With filter and HCS check on, drop uncorrectable or pattern-matching cells.
// - Pattern and mask cover GFC, PTI, CLP; VPI and VCI must be zero.
// - CRC-8 with x^8+x^2+x+1 over four header octets checks the HCS.
// - Coset x^6+x^4+x^2+1 is added to received HCS before comparison.
// - Correction mode passes clean cells, fixes single errors, any error moves on.
// - Detection mode drops errored cells; a clean cell passes and returns.
// - Eight-bit saturating count of single errors seen in correction mode.
// - Eight-bit saturating count of uncorrectable HCS errors.
// - Nineteen-bit count of received assigned cells.
// - Counters advance only in SYNC and hold otherwise.
// - A read latches a counter and restarts it at 0, or 1 on coincident event.
// - GFC bits leave serially with an MSB pulse; output low out of SYNC.
// - Each GFC bit position can be kept from updating the serial output.
// - FIFO holds four cells with pointers and a cell-available indication.
// - On overrun drop cells until one is read; flag and interrupt.
// - A read of an empty FIFO is ignored and pointers stay.
// - Reads on the read clock mark the first octet and drive cell-available.
// - Cell-available drops at the cell boundary or four reads earlier.
// - In boundary mode read enable may stay on; valid marks real octets.
// - Each FIFO entry is a whole 53-byte cell.
`timescale 1ns/1ps
`default_nettype none
module atm_rx_cell_filter_fifo #(
    parameter int CELLS = cell_rx_pkg::FIFO_CELLS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire cell_rx_pkg::line_byte_type line_in,
    input wire logic line_valid,
    output logic line_ready,
    input wire logic in_sync,
    input wire logic filter_enable,
    input wire logic hcs_check_enable,
    input wire cell_rx_pkg::hdr_fields_type match_pattern,
    input wire cell_rx_pkg::hdr_fields_type match_mask,
    input wire logic [3:0] gfc_update_enable,
    input wire logic cell_avail_early,
    input wire logic [2:0] count_read,
    output logic [7:0] count_corr,
    output logic [7:0] count_uncorr,
    output logic [18:0] count_cells,
    output logic gfc_serial_out,
    output logic gfc_msb_position_pulse,
    input wire logic rx_fifo_read_clock,
    input wire logic rx_fifo_read_enable_n,
    output logic [7:0] rx_data,
    output logic rx_start_of_cell,
    output logic rx_data_valid,
    output logic rx_cell_available,
    input wire logic overrun_int_enable,
    input wire logic overrun_clear,
    output logic overrun_status,
    output logic overrun_irq
);
    import cell_rx_pkg::*;

    localparam int SW = $clog2(CELLS);
    localparam int PW = SW + 1;
    localparam logic [PW-1:0] FULL_CELLS = PW'(CELLS);
    localparam logic [PW-1:0] ONE_CELL = PW'(1);

    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Maps a syndrome to the one flipped bit, zero when none matches
    function automatic logic [39:0] locate_error(input logic [7:0] syn);
        logic [39:0] m;
        m = '0;
        for (int i = 0; i < 32; i++) begin
            if (crc8(32'h1 << i) == syn) begin
                m[i+8] = 1'b1;
            end
        end
        for (int j = 0; j < 8; j++) begin
            if ((8'h01 << j) == syn) begin
                m[j] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [7:0] hdr_byte(input logic [39:0] h,
                                            input logic [5:0] i);
        logic [39:0] s;
        s = h >> (8 * (HCS_IDX - i));
        return s[7:0];
    endfunction

    line_byte_type st_data;
    logic st_valid;
    logic st_ready;
    logic decide_q;
    logic pop;

    // Staging absorbs line bytes while the header decision stalls the drain
    cell_byte_fifo #(
        .WIDTH($bits(line_byte_type)),
        .DEPTH(STAGE_DEPTH)
    ) u_stage (
        .clk(core_clk),
        .rst(rst),
        .in_valid(line_valid),
        .in_ready(line_ready),
        .in_data(line_in),
        .out_valid(st_valid),
        .out_ready(st_ready),
        .out_data(st_data)
    );

    assign st_ready = !decide_q;
    assign pop = st_valid & st_ready;

    logic [5:0] in_idx_q;
    logic [5:0] cur_idx;
    logic [31:0] hdr_q;
    logic [7:0] hcs_q;
    assign cur_idx = st_data.first ? FIRST_BYTE : in_idx_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_idx_q <= FIRST_BYTE;
            decide_q <= 1'b0;
        end else begin
            decide_q <= pop && (cur_idx == HCS_IDX);
            if (pop) begin
                in_idx_q <= (cur_idx == LAST_BYTE) ? FIRST_BYTE
                                                   : cur_idx + 6'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hdr_q <= '0;
            hcs_q <= '0;
        end else if (pop && cur_idx < HCS_IDX) begin
            hdr_q <= {hdr_q[23:0], st_data.data};
        end else if (pop && cur_idx == HCS_IDX) begin
            hcs_q <= st_data.data;
        end
    end

    // Header decision
    hcs_mode_type mode_q;
    logic [7:0] syn;
    logic [39:0] emask;
    logic [39:0] fixed;
    logic any_err;
    logic single_err;
    logic uncorr;
    logic idle_like;
    logic match;
    logic drop;
    hdr_fields_type fields;

    assign syn = crc8(hdr_q) ^ hcs_q ^ HCS_COSET;
    assign emask = locate_error(syn);
    assign any_err = (syn != 8'h00);
    assign single_err = |emask;
    assign fixed = {hdr_q, hcs_q} ^
        ((hcs_check_enable && mode_q == MODE_CORRECT) ? emask : '0);
    assign uncorr = (mode_q == MODE_DETECT && any_err) ||
                    (mode_q == MODE_CORRECT && any_err && !single_err);
    assign fields = {fixed[39:36], fixed[11:9], fixed[8]};
    assign idle_like = (fixed[35:12] == '0);
    assign match = idle_like &&
                   (((fields ^ match_pattern) & match_mask) == '0);
    // Uncorrectable cells go even with filtering off, as the modes demand
    assign drop = hcs_check_enable &&
                  (uncorr || (filter_enable && match));

    always_ff @(posedge core_clk) begin
        if (rst || !in_sync) begin
            mode_q <= MODE_CORRECT;
        end else if (decide_q) begin
            case (mode_q)
                MODE_CORRECT: begin
                    if (any_err) begin
                        mode_q <= MODE_DETECT;
                    end
                end
                MODE_DETECT: begin
                    if (!any_err) begin
                        mode_q <= MODE_CORRECT;
                    end
                end
                default: begin
                    mode_q <= MODE_CORRECT;
                end
            endcase
        end
    end

    // Cell store
    logic [39:0] hdr_mem [CELLS];
    logic [7:0] pay_mem [CELLS][PAYLOAD_BYTES];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW-1:0] stored;
    logic full;
    logic start_ev;
    logic accept_q;
    logic keep_q;
    logic drop_mode_q;
    logic rd_done;
    logic pay_wr;

    assign stored = wr_ptr_q - rd_ptr_q;
    assign full = (stored == FULL_CELLS);
    assign start_ev = pop && (cur_idx == FIRST_BYTE);
    assign pay_wr = pop && cur_idx >= PAY_START && keep_q && accept_q;

    always_ff @(posedge core_clk) begin
        if (rst || !in_sync) begin
            accept_q <= 1'b0;
        end else if (start_ev) begin
            accept_q <= !full && !drop_mode_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            keep_q <= 1'b0;
        end else if (decide_q) begin
            keep_q <= accept_q && in_sync && !drop;
        end
    end

    always_ff @(posedge core_clk) begin
        if (decide_q && accept_q && in_sync && !drop) begin
            hdr_mem[wr_ptr_q[SW-1:0]] <= fixed;
        end
    end

    always_ff @(posedge core_clk) begin
        if (pay_wr) begin
            pay_mem[wr_ptr_q[SW-1:0]][cur_idx - PAY_START] <= st_data.data;
        end
    end

    // Only a fully received cell becomes visible to the reader
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
        end else if (pay_wr && cur_idx == LAST_BYTE) begin
            wr_ptr_q <= wr_ptr_q + ONE_CELL;
        end
    end

    // Overrun: a new cell finds the store full
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drop_mode_q <= 1'b0;
            overrun_status <= 1'b0;
            overrun_irq <= 1'b0;
        end else begin
            if (start_ev && in_sync && full) begin
                drop_mode_q <= 1'b1;
            end else if (rd_done) begin
                drop_mode_q <= 1'b0;
            end
            if (start_ev && in_sync && full) begin
                overrun_status <= 1'b1;
            end else if (overrun_clear) begin
                overrun_status <= 1'b0;
            end
            overrun_irq <= overrun_status && overrun_int_enable;
        end
    end

    // Performance counters
    logic [2:0] ev;
    logic [CNT_W-1:0] cnt_q [NUM_COUNTERS];
    logic [CNT_W-1:0] latch_q [NUM_COUNTERS];
    assign ev[CNT_CORR] = decide_q && in_sync && mode_q == MODE_CORRECT &&
                          single_err;
    assign ev[CNT_UNC] = decide_q && in_sync && uncorr;
    assign ev[CNT_CELLS] = decide_q && in_sync && !uncorr &&
                           !idle_like;

    for (genvar g = 0; g < NUM_COUNTERS; g++) begin : g_cnt
        always_ff @(posedge core_clk) begin
            if (rst) begin
                cnt_q[g] <= CNT_ZERO;
                latch_q[g] <= CNT_ZERO;
            end else if (count_read[g]) begin
                latch_q[g] <= cnt_q[g];
                cnt_q[g] <= ev[g] ? CNT_ONE : CNT_ZERO;
            end else if (ev[g] && cnt_q[g] != CNT_MAX[g]) begin
                cnt_q[g] <= cnt_q[g] + CNT_ONE;
            end
        end
    end

    assign count_corr = latch_q[CNT_CORR][CORR_W-1:0];
    assign count_uncorr = latch_q[CNT_UNC][UNC_W-1:0];
    assign count_cells = latch_q[CNT_CELLS];

    // Serial GFC port, one bit per core clock, MSB first
    logic [3:0] gfc_sh_q;
    logic [2:0] gfc_cnt_q;
    logic [1:0] gfc_pos;
    assign gfc_pos = 2'(gfc_cnt_q - 3'h1);

    always_ff @(posedge core_clk) begin
        if (rst || !in_sync) begin
            gfc_sh_q <= 4'h0;
            gfc_cnt_q <= 3'h0;
            gfc_serial_out <= 1'b0;
            gfc_msb_position_pulse <= 1'b0;
        end else if (decide_q) begin
            gfc_sh_q <= fixed[39:36];
            gfc_cnt_q <= GFC_BITS;
            gfc_msb_position_pulse <= 1'b0;
        end else if (gfc_cnt_q != 3'h0) begin
            if (gfc_update_enable[gfc_pos]) begin
                gfc_serial_out <= gfc_sh_q[gfc_pos];
            end
            gfc_msb_position_pulse <= (gfc_cnt_q == GFC_MSB_CNT);
            gfc_cnt_q <= gfc_cnt_q - 3'h1;
        end else begin
            gfc_msb_position_pulse <= 1'b0;
        end
    end

    // Read side: the read clock is a pin, sampled and edge-detected here
    logic rclk_s1_q;
    logic rclk_s2_q;
    logic rclk_s3_q;
    logic ren_s1_q;
    logic ren_s2_q;
    logic rd_edge;
    logic take;
    logic [5:0] rd_idx_q;
    logic [39:0] rd_hdr;
    logic [7:0] rd_byte;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rclk_s1_q <= 1'b0;
            rclk_s2_q <= 1'b0;
            rclk_s3_q <= 1'b0;
            ren_s1_q <= 1'b1;
            ren_s2_q <= 1'b1;
        end else begin
            rclk_s1_q <= rx_fifo_read_clock;
            rclk_s2_q <= rclk_s1_q;
            rclk_s3_q <= rclk_s2_q;
            ren_s1_q <= rx_fifo_read_enable_n;
            ren_s2_q <= ren_s1_q;
        end
    end

    assign rd_edge = rclk_s2_q && !rclk_s3_q;
    assign take = rd_edge && !ren_s2_q && stored != '0;
    assign rd_done = take && rd_idx_q == LAST_BYTE;
    assign rd_hdr = hdr_mem[rd_ptr_q[SW-1:0]];
    assign rd_byte = (rd_idx_q < PAY_START) ? hdr_byte(rd_hdr, rd_idx_q)
        : pay_mem[rd_ptr_q[SW-1:0]][rd_idx_q - PAY_START];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_ptr_q <= '0;
            rd_idx_q <= FIRST_BYTE;
            rx_data <= 8'h00;
            rx_start_of_cell <= 1'b0;
            rx_data_valid <= 1'b0;
        end else if (take) begin
            rx_data <= rd_byte;
            rx_start_of_cell <= (rd_idx_q == FIRST_BYTE);
            rx_data_valid <= 1'b1;
            rd_idx_q <= rd_done ? FIRST_BYTE : rd_idx_q + 6'h01;
            if (rd_done) begin
                rd_ptr_q <= rd_ptr_q + ONE_CELL;
            end
        end else if (rd_edge) begin
            rx_start_of_cell <= 1'b0;
            rx_data_valid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_cell_available <= 1'b0;
        end else begin
            rx_cell_available <= (stored > ONE_CELL) ||
                (stored == ONE_CELL &&
                 !(cell_avail_early && rd_idx_q >= EARLY_IDX));
        end
    end

    property p_gfc_low;
        @(posedge core_clk) disable iff (rst)
        !in_sync |=> !gfc_serial_out && !gfc_msb_position_pulse;
    endproperty
    a_gfc_low: assert property (p_gfc_low)
        else $error("GFC output not low out of sync");

    property p_hold;
        @(posedge core_clk) disable iff (rst)
        (!in_sync && count_read == 3'h0) |=>
            $stable(cnt_q[0]) && $stable(cnt_q[1]) && $stable(cnt_q[2]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Counter moved outside sync");

    property p_read_latch;
        @(posedge core_clk) disable iff (rst)
        count_read[0] |=> count_corr == $past(cnt_q[0][7:0]) &&
            cnt_q[0] == ($past(ev[0]) ? CNT_ONE : CNT_ZERO);
    endproperty
    a_read_latch: assert property (p_read_latch)
        else $error("Counter read did not latch and restart");

    property p_saturate;
        @(posedge core_clk) disable iff (rst)
        (cnt_q[1] == CNT_MAX[1] && !count_read[1]) |=>
            cnt_q[1] == CNT_MAX[1];
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("Uncorrectable counter wrapped");

    property p_underrun;
        @(posedge core_clk) disable iff (rst)
        (rd_edge && !ren_s2_q && stored == '0) |=>
            $stable(rd_ptr_q) && $stable(rd_idx_q) && !rx_data_valid;
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("Empty read moved the read side");

    property p_overrun;
        @(posedge core_clk) disable iff (rst)
        (start_ev && in_sync && full) |=> overrun_status && !accept_q
            ##1 (overrun_irq == overrun_int_enable);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("Overrun not flagged or cell accepted");

    property p_depth;
        @(posedge core_clk) disable iff (rst)
        stored <= FULL_CELLS;
    endproperty
    a_depth: assert property (p_depth)
        else $error("More cells stored than the FIFO holds");

    property p_soc;
        @(posedge core_clk) disable iff (rst)
        (take && rd_idx_q == FIRST_BYTE) |=> rx_start_of_cell
            && rx_data_valid;
    endproperty
    a_soc: assert property (p_soc)
        else $error("First octet not marked");

    property p_detect_drop;
        @(posedge core_clk) disable iff (rst)
        (decide_q && hcs_check_enable && mode_q == MODE_DETECT && any_err)
            |=> !keep_q;
    endproperty
    a_detect_drop: assert property (p_detect_drop)
        else $error("Errored cell kept in detection mode");

    property p_early;
        @(posedge core_clk) disable iff (rst)
        (cell_avail_early && stored == ONE_CELL && rd_idx_q >= EARLY_IDX)
            |=> !rx_cell_available;
    endproperty
    a_early: assert property (p_early)
        else $error("Cell available not dropped early");
endmodule // atm_rx_cell_filter_fifo
`default_nettype wire

/* File: logic/cell_rx_pkg.sv */
// Shared constants and types for the receive cell filter and FIFO.
// Assumes byte-wide delineated cells and one core clock domain.
package cell_rx_pkg;
    localparam int FIFO_CELLS = 4;
    localparam int PAYLOAD_BYTES = 48;
    localparam int STAGE_DEPTH = 8;
    localparam int NUM_COUNTERS = 3;
    localparam int CNT_W = 19;
    localparam int CORR_W = 8;
    localparam int UNC_W = 8;
    localparam int CNT_CORR = 0;
    localparam int CNT_UNC = 1;
    localparam int CNT_CELLS = 2;
    localparam logic [CNT_W-1:0] CNT_MAX [NUM_COUNTERS] =
        '{19'h000FF, 19'h000FF, 19'h7FFFF};
    localparam logic [CNT_W-1:0] CNT_ZERO = 19'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 19'h00001;
    localparam logic [5:0] FIRST_BYTE = 6'h00;
    localparam logic [5:0] HCS_IDX = 6'h04;
    localparam logic [5:0] PAY_START = 6'h05;
    localparam logic [5:0] LAST_BYTE = 6'h34;
    // Cell-available drops this many reads early in early mode
    localparam logic [5:0] EARLY_READS = 6'h04;
    localparam logic [5:0] EARLY_IDX = LAST_BYTE + 6'h01 - EARLY_READS;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] HCS_COSET = 8'h55;
    localparam logic [2:0] GFC_BITS = 3'h4;
    localparam logic [2:0] GFC_MSB_CNT = 3'h4;

    typedef struct packed {
        logic first;
        logic [7:0] data;
    } line_byte_type;

    typedef struct packed {
        logic [3:0] gfc;
        logic [2:0] pti;
        logic clp;
    } hdr_fields_type;

    typedef enum logic [1:0] {
        MODE_CORRECT = 2'b01,
        MODE_DETECT = 2'b10
    } hcs_mode_type;
endpackage

/* File: logic/cell_byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/1ps
`default_nettype none
module cell_byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic room_q;
    logic push;
    logic pop;

    assign push = in_valid & room_q;
    assign pop = out_valid & out_ready;
    assign in_ready = room_q;
    assign out_valid = (count_q != '0);
    assign out_data = mem[rd_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Ready is registered so the filling side sees a clean level
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            room_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            count_q <= count_d;
            room_q <= (count_d != FULL);
        end
    end
endmodule // cell_byte_fifo
`default_nettype wire

/* File: tb/atm_layer_reader.sv */
// ATM layer reader model: clocks octets out of the receive FIFO.
// Assumes run is a level from the bench; clock stands still while low.
`timescale 1ns/1ps
`default_nettype none
module atm_layer_reader (
    input wire logic run,
    input wire logic [7:0] rx_data,
    input wire logic rx_start_of_cell,
    input wire logic rx_data_valid,
    output logic rx_fifo_read_clock,
    output logic rx_fifo_read_enable_n
);
    logic [7:0] got [0:1023];
    int n_got = 0;
    int n_soc = 0;
    // Answer to one edge stands until the next, so it is taken there
    initial begin
        rx_fifo_read_clock = 1'b0;
        rx_fifo_read_enable_n = 1'b1;
        forever begin
            #100;
            if (run) begin
                rx_fifo_read_clock = 1'b1;
                if (rx_data_valid === 1'b1) begin
                    // A misplaced start mark spoils the count on purpose
                    if (rx_start_of_cell === 1'b1)
                        n_soc += (n_got % 53 == 0) ? 1 : 1000;
                    got[n_got] = rx_data;
                    n_got++;
                end
            end
            #100;
            rx_fifo_read_clock = 1'b0;
            rx_fifo_read_enable_n = !run;
        end
    end
endmodule // atm_layer_reader
`default_nettype wire

/* File: tb/atm_rx_cell_filter_fifo_tb.sv */
// Bench for the receive cell filter and FIFO with a reader model.
// Assumes the design package and the reader model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module atm_rx_cell_filter_fifo_tb;
    import cell_rx_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, line_valid = 1'b0, line_ready;
    line_byte_type line_in = '0;
    logic in_sync = 1'b1, run = 1'b0, rclk, ren_n;
    logic ov_clr = 1'b0, early = 1'b0;
    hdr_fields_type pat = 8'hA0, msk = 8'hF0;
    logic [2:0] count_read = 3'h0;
    logic [7:0] c_corr, c_unc, rx_data;
    logic [18:0] c_cells;
    logic gfc_o, gfc_p, soc, dv, ca, ov_st, ov_irq;
    logic [31:0] lfsr_q = 32'h83F9AF2D;
    logic [7:0] exp_q [$];
    int bad_count = 0, cmp_count = 0, cells = 0;
    logic [3:0] gfc_exp [$];
    logic [3:0] gfc_got, gfc_e;
    int gfc_n = 0;
    always #12.5 core_clk = ~core_clk;
    // Collects the four serial GFC bits, starting with the one that comes out with each position pulse
    always @(negedge core_clk) begin
        if (gfc_p === 1'b1)
            gfc_n = 4;
        if (gfc_n > 0) begin
            gfc_n--;
            gfc_got[gfc_n] = gfc_o;
            if (gfc_n == 0) begin
                gfc_e = gfc_exp.pop_front();
                `CHK("gfc", gfc_e, gfc_got)
            end
        end
    end
    atm_rx_cell_filter_fifo uut (.core_clk(core_clk), .rst(rst),
        .line_in(line_in), .line_valid(line_valid), .line_ready(line_ready),
        .in_sync(in_sync), .filter_enable(1'b1), .hcs_check_enable(1'b1),
        .match_pattern(pat), .match_mask(msk), .gfc_update_enable(4'hF),
        .cell_avail_early(early), .count_read(count_read),
        .count_corr(c_corr), .count_uncorr(c_unc), .count_cells(c_cells),
        .gfc_serial_out(gfc_o), .gfc_msb_position_pulse(gfc_p),
        .rx_fifo_read_clock(rclk), .rx_fifo_read_enable_n(ren_n),
        .rx_data(rx_data), .rx_start_of_cell(soc), .rx_data_valid(dv),
        .rx_cell_available(ca), .overrun_int_enable(1'b1),
        .overrun_clear(ov_clr), .overrun_status(ov_st), .overrun_irq(ov_irq));
    atm_layer_reader p (.run(run), .rx_data(rx_data),
        .rx_start_of_cell(soc), .rx_data_valid(dv),
        .rx_fifo_read_clock(rclk), .rx_fifo_read_enable_n(ren_n));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] hcs_of(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? CRC_POLY : 8'h00);
        return c ^ HCS_COSET;
    endfunction
    // Random header with nonzero path fields, so it is an assigned cell
    function automatic logic [31:0] rand_hdr(input logic [31:0] r);
        return {r[31:28], r[27:4] | 24'h000010, r[3:0]};
    endfunction
    task automatic send_cell(input logic [31:0] h, input logic [31:0] err,
                             input bit keep);
        logic [7:0] b;
        for (int i = 0; i < 53; i++) begin
            lfsr_q = lfsr(lfsr_q);
            b = (i < 4) ? 8'(h >> (24 - 8 * i)) : lfsr_q[7:0];
            if (i == 4)
                b = hcs_of(h);
            if (keep)
                exp_q.push_back(b);
            if (i < 4)
                b ^= 8'(err >> (24 - 8 * i));
            @(negedge core_clk);
            line_in <= '{first: (i == 0), data: b};
            line_valid <= 1'b1;
            if (i == 0 && in_sync)
                gfc_exp.push_back(h[31:28]);
            @(posedge core_clk);
            while (line_ready !== 1'b1)
                @(posedge core_clk);
        end
        @(negedge core_clk);
        line_valid <= 1'b0;
        repeat (6) @(negedge core_clk);
        cells += keep;
    endtask
    task automatic drain(input string nm);
        run = 1'b1;
        for (int t = 0; t < 60000 && p.n_got < exp_q.size(); t++)
            @(posedge core_clk);
        if (p.n_got < exp_q.size())
            bad_count++;
        repeat (200) @(posedge core_clk);
        run = 1'b0;
        $display("test %s done", nm);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst <= 1'b0;
        repeat (4) @(negedge core_clk);
        drain("underrun");
        lfsr_q = lfsr(lfsr_q);
        send_cell(rand_hdr(lfsr_q), 32'h0, 1'b1);
        send_cell(rand_hdr(lfsr_q), 32'h00000100, 1'b1);
        send_cell(rand_hdr(lfsr_q), 32'h00010000, 1'b0);
        send_cell(rand_hdr(lfsr_q), 32'h0, 1'b1);
        early <= 1'b1;
        drain("modes");
        early <= 1'b0;
        send_cell(rand_hdr(lfsr_q), 32'h00000300, 1'b0);
        send_cell(rand_hdr(lfsr_q), 32'h0, 1'b1);
        send_cell(32'hA0000002, 32'h0, 1'b0);
        send_cell(32'h5000000C, 32'h0, 1'b1);
        drain("filter");
        for (int k = 0; k < 5; k++)
            send_cell(rand_hdr(lfsr_q), 32'h0, k < FIFO_CELLS);
        `CHK("overrun_status", 1'b1, ov_st)
        `CHK("overrun_irq", 1'b1, ov_irq)
        ov_clr <= 1'b1;
        @(negedge core_clk);
        ov_clr <= 1'b0;
        `CHK("overrun_clear", 1'b0, ov_st)
        drain("overrun");
        for (int k = 0; k < exp_q.size(); k++)
            `CHK("octet", exp_q[k], p.got[k])
        `CHK("octets", exp_q.size(), p.n_got)
        `CHK("starts", cells, p.n_soc)
        `CHK("cell_available", 1'b0, ca)
        for (int r = 0; r < 2; r++) begin
            @(negedge core_clk);
            count_read <= 3'h7;
            @(negedge core_clk);
            count_read <= 3'h0;
            `CHK("corr", (r == 0) ? 8'h01 : 8'h00, c_corr)
            `CHK("uncorr", (r == 0) ? 8'h02 : 8'h00, c_unc)
            `CHK("cells", (r == 0) ? 19'h9 : 19'h0, c_cells)
        end
        in_sync <= 1'b0;
        send_cell(rand_hdr(lfsr_q), 32'h0, 1'b0);
        `CHK("gfc_out", 1'b0, gfc_o)
        drain("no_sync");
        `CHK("octets_nosync", exp_q.size(), p.n_got)
        @(negedge core_clk);
        count_read <= 3'h4;
        @(negedge core_clk);
        count_read <= 3'h0;
        `CHK("cells_nosync", 19'h0, c_cells)
        `CHK("gfc_left", 0, gfc_exp.size())
        report_and_stop();
    end
endmodule // atm_rx_cell_filter_fifo_tb
`default_nettype wire
